//--- rtl/sia_agent.sv
// serial interrupt slave agent: reports levels on the shared line
// assumes the host terminates the line and keeps its own timing
`timescale 1ns/1ps
module sia_agent #(
	parameter int IRQ_LINES = 15
) (
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	// interrupt sources, bit i is interrupt i+1
	input  wire logic [IRQ_LINES-1:0] irq_lvl,
	input  wire logic                 system_mgmt_irq_n,
	input  wire logic                 smi_on_frame3,
	// shared line
	input  wire logic                 serirq_in,
	output sia_pkg::sia_pin_type      serirq_pin,
	// status
	output logic                      quiet_mode,
	output logic                      cycle_active
);
	localparam int PW = sia_pkg::POS_W;
	localparam int RW = sia_pkg::RUN_W;
	localparam int HW = sia_pkg::HOLD_W;
	localparam int FL = sia_pkg::LAST_FRAME;
	localparam int FD = sia_pkg::FIRST_DATA;

	logic [IRQ_LINES+2:0] sync_s;
	logic [IRQ_LINES-1:0] irq_s;
	logic                 smi_s;
	logic                 smi_sel_s;
	logic                 line_s;
	logic                 line_prev_q;
	logic                 rise;
	logic [RW-1:0]        run_q;
	logic [PW-1:0]        pos_q;
	logic [PW-1:0]        pos_d;
	logic                 active_q;
	logic                 active_d;
	logic                 quiet_q;
	logic                 quiet_d;
	logic [FL:FD]         frame_lvl;
	logic [FL:FD]         frame_prev_q;
	logic [FL:FD]         pending_q;
	logic [FL:FD]         served;
	logic                 sample_low;
	logic                 recover;
	logic                 start_d;
	logic                 start_q;
	logic [HW-1:0]        hold_q;
	logic                 oe_q;
	logic                 o_q;

	initial begin
		if (IRQ_LINES < 2 || IRQ_LINES > FL - 1) begin
			$error("sia_agent: IRQ_LINES must be 2 to 15");
		end
	end

	// pin and sources cross in through two flops
	sia_sync #(
		.WIDTH   (IRQ_LINES + 3),
		.RST_VAL (sia_pkg::LEVEL_RESET)
	) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.d        ({smi_on_frame3, system_mgmt_irq_n, irq_lvl, serirq_in}),
		.q        (sync_s)
	);

	assign line_s    = sync_s[0];
	assign irq_s     = sync_s[IRQ_LINES:1];
	assign smi_s     = sync_s[IRQ_LINES+1];
	assign smi_sel_s = sync_s[IRQ_LINES+2];

	// level carried by each data frame; absent lines read high
	always_comb begin
		frame_lvl = '1;
		for (int n = FD; n <= FL; n++) begin
			if (n - FD < IRQ_LINES) begin
				frame_lvl[n] = irq_s[n-FD];
			end
		end
		if (smi_sel_s) begin
			frame_lvl[sia_pkg::SMI_FRAME] = smi_s;
		end
	end

	// edge and low-run tracking of the line
	assign rise = line_s & ~line_prev_q;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			line_prev_q <= sia_pkg::LEVEL_RESET;
		end else begin
			line_prev_q <= line_s;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			run_q <= '0;
		end else if (line_s) begin
			run_q <= '0;
		end else if (run_q != '1) begin
			run_q <= run_q + RW'(1);
		end
	end

	// cycle framing and mode decode
	always_comb begin
		active_d = active_q;
		quiet_d  = quiet_q;
		pos_d    = (pos_q == '1) ? pos_q : pos_q + PW'(1);
		if (rise && !active_q) begin
			active_d = 1'b1;
			pos_d    = PW'(sia_pkg::START_POS);
		end else if (rise && run_q == RW'(sia_pkg::STOP_QUIET_LEN)) begin
			active_d = 1'b0;
			quiet_d  = 1'b1;
		end else if (rise && run_q == RW'(sia_pkg::STOP_CONT_LEN)) begin
			active_d = 1'b0;
			quiet_d  = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			active_q <= 1'b0;
			pos_q    <= '0;
		end else begin
			active_q <= active_d;
			pos_q    <= pos_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			quiet_q <= sia_pkg::MODE_RESET_QUIET;
		end else begin
			quiet_q <= quiet_d;
		end
	end

	// slot decode for the position the outputs will show next
	always_comb begin
		sample_low = 1'b0;
		served     = '0;
		recover    = 1'b0;
		for (int n = FD; n <= FL; n++) begin
			if (active_d && pos_d == PW'(sia_pkg::FRAME_CLOCKS * n - 1)) begin
				served[n]  = 1'b1;
				sample_low = ~frame_lvl[n];
			end
		end
		// only right after our own low sample
		if (active_d && oe_q && !o_q && !start_q) begin
			recover = 1'b1;
		end
	end

	// pending changes; a change in the serving cycle wins over the clear
	always_ff @(posedge core_clk) begin
		if (rst) begin
			frame_prev_q <= '1;
			pending_q    <= '0;
		end else begin
			frame_prev_q <= frame_lvl;
			pending_q    <= (pending_q & ~served) | (frame_lvl ^ frame_prev_q);
		end
	end

	// own start: quiet, idle, line seen high, no other start seen
	assign start_d = quiet_q && !active_q && !active_d && line_s && run_q == '0
		&& hold_q == '0 && |pending_q;

	// guard covers the synchroniser delay before our own low is seen
	always_ff @(posedge core_clk) begin
		if (rst) begin
			hold_q <= '0;
		end else if (start_d) begin
			hold_q <= HW'(sia_pkg::HOLD_CYCLES);
		end else if (hold_q != '0) begin
			hold_q <= hold_q - HW'(1);
		end
	end

	// registered drive; anything not listed is turnaround or idle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			oe_q    <= 1'b0;
			o_q     <= 1'b0;
			start_q <= 1'b0;
		end else begin
			oe_q    <= start_d | sample_low | recover;
			o_q     <= recover & ~start_d;
			start_q <= start_d;
		end
	end

	assign serirq_pin.o  = o_q;
	assign serirq_pin.oe = oe_q;
	assign quiet_mode    = quiet_q;
	assign cycle_active  = active_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_start_quiet_idle: assert property (start_q |-> $past(quiet_q) && $past(!active_q))
		else $error("start pulse outside quiet idle");
	a_start_one_low: assert property (start_q |-> !serirq_pin.o ##1 !serirq_pin.oe)
		else $error("start pulse not one clock low then released");
	a_no_start_active: assert property (active_q |-> !start_d)
		else $error("start pulse during active cycle");
	a_cont_passive: assert property (!quiet_q |=> !start_q)
		else $error("start in continuous mode");
	a_mode_at_stop: assert property ($changed(quiet_q) |-> $past(rise && active_q))
		else $error("mode changed outside stop pulse");
	a_reset_mode: assert property ($fell(rst) |-> !quiet_q)
		else $error("mode not continuous after reset");
	a_stop_quiet: assert property (rise && active_q && run_q == RW'(2) |=> quiet_q && !active_q)
		else $error("two clock stop not decoded as quiet");
	a_stop_cont: assert property (rise && active_q && run_q == RW'(3) |=> !quiet_q && !active_q)
		else $error("three clock stop not decoded as continuous");
	a_count_start: assert property (rise && !active_q |=> active_q && pos_q == PW'(3))
		else $error("frame count not started at rising edge");
	a_sample_slot: assert property (oe_q && !o_q && !start_q |-> pos_q % 3 == 2 && pos_q >= PW'(5))
		else $error("low drive outside a sample slot");
	a_recover_turn: assert property (oe_q && o_q |-> $past(oe_q && !o_q) ##1 !oe_q)
		else $error("recovery high not after own low or not released");
	// the default disable would silence this one exactly while reset is held
	a_reset_release: assert property (@(posedge core_clk) disable iff (1'b0) rst |=> !serirq_pin.oe)
		else $error("line driven during reset");

	c_own_start: cover property (start_q ##[1:20] active_q);
	c_quiet_stop: cover property (rise && active_q && run_q == RW'(2));
	c_cont_stop: cover property (rise && active_q && run_q == RW'(3));
	c_report_low: cover property (oe_q && !o_q && !start_q ##1 oe_q && o_q);
endmodule

//--- rtl/sia_pkg.sv
// constants and carrier types for the serial interrupt slave agent
// assumes a single bus clock; the shared line is resolved outside the design
package sia_pkg;

	// pin drive toward the shared line, resolved by the pad or testbench
	typedef struct packed {
		logic o;
		logic oe;
	} sia_pin_type;

	// frame positions counted from the start pulse rising edge
	localparam int POS_W           = 6;
	localparam int FIRST_DATA      = 2;
	localparam int SMI_FRAME       = 3;
	localparam int LAST_FRAME      = 16;
	localparam int FRAME_CLOCKS    = 3;

	// input synchroniser depth, and the position of the first cycle a rise can steer
	localparam int SYNC_STAGES     = 2;
	localparam int START_POS       = SYNC_STAGES + 1;

	// stop pulse widths in clocks
	localparam int STOP_QUIET_LEN  = 2;
	localparam int STOP_CONT_LEN   = 3;

	// low run counter width and the guard after our own start pulse
	localparam int RUN_W           = 4;
	localparam int HOLD_CYCLES     = 4;
	localparam int HOLD_W          = 3;

	// reset values
	localparam logic MODE_RESET_QUIET = 1'b0;
	localparam logic LEVEL_RESET      = 1'b1;

endpackage

//--- rtl/sia_sync.sv
// two flip-flop synchroniser for a vector of unrelated levels
// assumes every bit is a slow level; no bus coherence is implied
`timescale 1ns/1ps
module sia_sync #(
	parameter int   WIDTH   = 1,
	parameter logic RST_VAL = 1'b1
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// levels
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;

	initial begin
		if (WIDTH < 1) begin
			$error("sia_sync: WIDTH must be at least 1");
		end
	end

	// first stage feeds only the second
	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_q <= {WIDTH{RST_VAL}};
			q      <= {WIDTH{RST_VAL}};
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

//--- verif/sia_host.sv
// behavioural host controller on the shared interrupt line
// assumes the bench resolves the line with a pull-up
`timescale 1ns/1ps
module sia_host (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// control
	input  wire logic       go,
	input  wire logic [1:0] stop_len,
	// line
	input  wire logic       line,
	output logic            h_oe,
	output logic            h_o
);
	task automatic put(input logic oe, input logic o);
		h_oe <= oe;
		h_o  <= o;
		@(posedge core_clk);
	endtask
	initial begin
		h_oe = 1'b0;
		h_o  = 1'b1;
	end
	// a slave start is one clock low; stretch it to four
	always begin
		@(posedge core_clk);
		if (!rst && (go || !line)) begin
			repeat (go ? 4 : 3) put(1'b1, 1'b0);
			put(1'b1, 1'b1);
			put(1'b0, 1'b1);
			repeat (49) @(posedge core_clk);
			repeat (stop_len) put(1'b1, 1'b0);
			put(1'b1, 1'b1);
			put(1'b0, 1'b1);
		end
	end
endmodule

//--- verif/serial_irq_slave_agent_test.sv
// testbench for the serial interrupt slave agent
// assumes the line has a pull-up; the host model answers starts
`timescale 1ns/1ps
module serial_irq_slave_agent_test;
	logic                 core_clk;
	logic                 rst;
	logic [14:0]          irq_lvl;
	logic                 system_mgmt_irq_n;
	logic                 smi_on_frame3;
	logic                 go;
	logic [1:0]           stop_len;
	logic                 h_oe;
	logic                 h_o;
	logic                 quiet_mode;
	logic                 cycle_active;
	wire                  serirq_in;
	sia_pkg::sia_pin_type pin;
	int                   num_errors;
	int                   checked;
	assign serirq_in = ~((pin.oe & ~pin.o) | (h_oe & ~h_o));
	always #10 core_clk = ~core_clk;
	sia_agent DUT (
		.core_clk          (core_clk),
		.rst               (rst),
		.irq_lvl           (irq_lvl),
		.system_mgmt_irq_n (system_mgmt_irq_n),
		.smi_on_frame3     (smi_on_frame3),
		.serirq_in         (serirq_in),
		.serirq_pin        (pin),
		.quiet_mode        (quiet_mode),
		.cycle_active      (cycle_active)
	);
	sia_host host (
		.core_clk (core_clk),
		.rst      (rst),
		.go       (go),
		.stop_len (stop_len),
		.line     (serirq_in),
		.h_oe     (h_oe),
		.h_o      (h_o)
	);
	task automatic finish_test;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [1:0] got, input logic [1:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %b want %b", $time, got, exp);
		end
	endtask
	task automatic cmp_pin(input logic [1:0] exp);
		cmp({pin.oe, pin.oe & pin.o}, exp);
	endtask
	task automatic wait_line(input logic lvl);
		int n;
		n = 0;
		while (serirq_in !== lvl) begin
			@(negedge core_clk);
			n++;
			if (n > 200) begin
				num_errors++;
				$display("ERROR %0t line wait ran out", $time);
				finish_test();
			end
		end
	endtask
	task automatic idle_check(input int n);
		repeat (n) begin
			@(negedge core_clk);
			cmp_pin(2'b00);
		end
	endtask
	// follow one cycle from the start rise and judge each clock
	// c counts edges after the first high sample; frame n drives after edge 3n-2
	task automatic frames(input logic qm, input logic qm_next);
		int   c;
		int   n;
		logic low;
		wait_line(1'b0);
		wait_line(1'b1);
		for (c = 0; c < 50; c++) begin
			@(negedge core_clk);
			n = (c + 2) / 3;
			low = n >= 2 && n <= 16 && c % 3 != 0 &&
				((n == 3 && smi_on_frame3) ? !system_mgmt_irq_n : !irq_lvl[n-2]);
			cmp_pin({low, low && c % 3 == 2});
			cmp({1'b0, cycle_active}, {1'b0, c >= 2});
		end
		cmp({1'b0, quiet_mode}, {1'b0, qm});
		repeat (10) @(negedge core_clk);
		cmp({1'b0, quiet_mode}, {1'b0, qm_next});
		cmp({1'b0, cycle_active}, 2'b00);
	endtask
	task automatic host_cycle;
		stop_len = 2'd2;
		go = 1'b1;
		@(negedge core_clk);
		go = 1'b0;
		frames(1'b0, 1'b1);
	endtask
	task automatic own_start;
		int n;
		stop_len = 2'd3;
		smi_on_frame3 = 1'b0;
		irq_lvl[2] = 1'b0;
		n = 0;
		while (pin.oe !== 1'b1) begin
			@(negedge core_clk);
			n++;
			if (n > 20) begin
				num_errors++;
				$display("ERROR %0t own start never came", $time);
				finish_test();
			end
		end
		cmp_pin(2'b10);
		@(negedge core_clk);
		cmp_pin(2'b00);
		frames(1'b1, 1'b0);
	endtask
	initial begin
		core_clk = 1'b0;
		rst = 1'b1;
		irq_lvl = 15'h7FEF;
		system_mgmt_irq_n = 1'b0;
		smi_on_frame3 = 1'b1;
		go = 1'b0;
		stop_len = 2'd2;
		num_errors = 0;
		checked = 0;
		repeat (13) @(negedge core_clk);
		cmp_pin(2'b00);
		cmp({1'b0, quiet_mode}, 2'b00);
		rst = 1'b0;
		idle_check(30);
		host_cycle();
		own_start();
		irq_lvl[2] = 1'b1;
		idle_check(30);
		finish_test();
	end
endmodule
